// [verilog/timer_mode_pkg.sv]
// Behaviour
// R1 - Phase select makes channel 2 quadrature up/down
// R2 - Count both edges; direction from other pin
// R3 - Phase mode ignores edge and prescale ticks
// R4 - Clear, compare, capture, flags still work
// R5 - Direction bit 0 flags both wraps; 1 overflow
// R6 - PWM bit: pin set on A, cleared on B
// R7 - Combination PWM overrides channel 3, 4 PWM bits
// R8 - Combination field: 0x normal, 10 comp, 11 reset-sync
// R9 - Software changes combination only with counter stopped
// R10 - Complementary mode forbids both sync bits set
// R11 - Buffer bits pair general with buffer registers
// R12 - Bit 7 undefined; function bit 6 reads 1
// R13 - Reset or standby clears mode register bits
// R14 - Reset or standby: function register reads 0x40
// R15 - Overflow is FFFF to 0; underflow 0 to FFFF
// R16 - Quadrature pins synchronised, edges from synced samples
package timer_mode_pkg;

   // ********************************
   // Register map
   // ********************************
   localparam logic [7:0] mode_offset     = 8'h00;
   localparam logic [7:0] function_offset = 8'h04;
   localparam logic [7:0] status_offset   = 8'h08;
   localparam logic [7:0] counter_offset  = 8'h0C;

   // ********************************
   // Field positions
   // ********************************
   localparam int phase_count_bit    = 6;
   localparam int flag_direction_bit = 5;
   localparam int pwm_lsb            = 0;
   localparam int combination_lsb    = 4;
   localparam int fixed_one_bit      = 6;
   localparam int buffer_lsb         = 0;
   localparam int overflow_flag_bit  = 0;

   // ********************************
   // Reset values and masks
   // ********************************
   localparam logic [7:0]  mode_reset      = 8'h00;
   localparam logic [7:0]  mode_mask       = 8'h7F;
   localparam logic [7:0]  function_reset  = 8'h40;
   localparam logic [7:0]  function_mask   = 8'h3F;
   localparam logic [15:0] counter_max     = 16'hFFFF;
   localparam logic [15:0] counter_zero    = 16'h0000;

   typedef enum logic [1:0]
   {
      comb_normal0   = 2'b00,
      comb_normal1   = 2'b01,
      comb_comp_pwm  = 2'b10,
      comb_reset_pwm = 2'b11
   } combination_t;

endpackage

// [verilog/quadrature_decoder.sv]
`timescale 1ns/1ps
module quadrature_decoder
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pin_a,
   input  wire logic pin_b,
   output logic      count_up,
   output logic      count_down
);

   // ********************************
   // Synchronisers and edge history
   // ********************************
   logic [1:0] meta_reg;
   logic [1:0] sync_reg;
   logic [1:0] prev_reg;
   logic       a_rise;
   logic       a_fall;
   logic       b_rise;
   logic       b_fall;
   logic       dec;
   logic       inc;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_reg <= 2'h0;
         sync_reg <= 2'h0;
         prev_reg <= 2'h0;
      end
      else
      begin
         meta_reg <= {pin_b, pin_a};            // R16
         sync_reg <= meta_reg;                  // R16
         prev_reg <= sync_reg;
      end
   end

   // ********************************
   // Direction decode
   // ********************************
   assign a_rise = sync_reg[0] & ~prev_reg[0];
   assign a_fall = ~sync_reg[0] & prev_reg[0];
   assign b_rise = sync_reg[1] & ~prev_reg[1];
   assign b_fall = ~sync_reg[1] & prev_reg[1];
   assign dec = (a_rise & ~sync_reg[1]) | (b_rise & sync_reg[0])
              | (a_fall & sync_reg[1]) | (b_fall & ~sync_reg[0]);   // R2
   assign inc = (a_rise & sync_reg[1]) | (b_fall & sync_reg[0])
              | (a_fall & ~sync_reg[1]) | (b_rise & ~sync_reg[0]);  // R2
   assign count_up   = inc & ~dec;
   assign count_down = dec & ~inc;

endmodule // quadrature_decoder

// [verilog/pwm_pin.sv]
`timescale 1ns/1ps
module pwm_pin
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic enable,
   input  wire logic match_a,
   input  wire logic match_b,
   output logic      pin_level
);

   // ********************************
   // Set on A match, clear on B match
   // ********************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_level <= 1'b0;
      else if (!enable)
         pin_level <= 1'b0;
      else if (match_a)
         pin_level <= 1'b1;                     // R6
      else if (match_b)
         pin_level <= 1'b0;                     // R6
   end

endmodule // pwm_pin

// [verilog/timer_mode_function_control.sv]
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module timer_mode_function_control
#(
   parameter int channels = 5,
   parameter int counter_width = 16
)
(
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic [31:0]                   prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic                     standby,
   input  wire logic                     ext_clock_pin_a,
   input  wire logic                     ext_clock_pin_b,
   input  wire logic                     ch2_run,
   input  wire logic                     ch2_count_tick,
   input  wire logic                     ch2_clear,
   input  wire logic [channels-1:0]      match_a,
   input  wire logic [channels-1:0]      match_b,
   output logic [channels-1:0]           pwm_active,
   output logic [channels-1:0]           compare_pin_a,
   output logic [counter_width-1:0]      channel2_counter,
   output logic                          overflow_flag,
   output logic                          ch2_phase_mode,
   output logic                          complementary_pwm,
   output logic                          reset_sync_pwm,
   output logic [3:0]                    buffer_mode
);

   // ********************************
   // Elaboration checks
   // ********************************
   if (channels != 5)
      $error("channels must be 5");
   if (counter_width != 16)
      $error("counter_width must be 16");

   // ********************************
   // Declarations
   // ********************************
   logic [7:0]               timer_mode_select;
   logic [7:0]               timer_function_control;
   logic [counter_width-1:0] counter_reg;
   logic [counter_width-1:0] counter_next;
   logic                     overflow_reg;
   logic                     overflow_set;
   logic                     wrap_up;
   logic                     wrap_down;
   logic                     quad_up;
   logic                     quad_down;
   logic                     step_up;
   logic                     step_down;
   logic                     setup;
   logic                     wr_setup;
   logic                     phase_count_select;
   logic                     flag_direction_select;
   logic [1:0]               combination_mode;
   logic                     combined;
   logic [channels-1:0]      pwm_enable;
   logic [31:0]              read_mux;
   logic                     mapped;

   // ********************************
   // Address decode
   // ********************************
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
      hit = (addr == offset);
   endfunction

   assign setup    = psel & ~penable;
   assign wr_setup = psel & penable & pwrite;
   assign mapped   = hit(paddr, timer_mode_pkg::mode_offset)
                   | hit(paddr, timer_mode_pkg::function_offset)
                   | hit(paddr, timer_mode_pkg::status_offset)
                   | hit(paddr, timer_mode_pkg::counter_offset);
   assign pready   = 1'b1;

   // ********************************
   // Mode register
   // ********************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         timer_mode_select <= timer_mode_pkg::mode_reset;                  // R13
      else if (standby)
         timer_mode_select <= timer_mode_pkg::mode_reset;                  // R13
      else if (wr_setup && hit(paddr, timer_mode_pkg::mode_offset))
         timer_mode_select <= pwdata[7:0] & timer_mode_pkg::mode_mask;     // R12
   end

   // ********************************
   // Function register
   // ********************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         timer_function_control <= timer_mode_pkg::function_reset;         // R14
      else if (standby)
         timer_function_control <= timer_mode_pkg::function_reset;         // R14
      else if (wr_setup && hit(paddr, timer_mode_pkg::function_offset))
         timer_function_control <= (pwdata[7:0] & timer_mode_pkg::function_mask)
                                 | timer_mode_pkg::function_reset;         // R12
   end

   // ********************************
   // Mode decode
   // ********************************
   assign phase_count_select    = timer_mode_select[timer_mode_pkg::phase_count_bit];
   assign flag_direction_select = timer_mode_select[timer_mode_pkg::flag_direction_bit];
   assign combination_mode      = timer_function_control[timer_mode_pkg::combination_lsb +: 2];

   always_comb
   begin
      complementary_pwm = 1'b0;
      reset_sync_pwm    = 1'b0;
      case (combination_mode)                                              // R8
         timer_mode_pkg::comb_normal0:   complementary_pwm = 1'b0;
         timer_mode_pkg::comb_normal1:   complementary_pwm = 1'b0;
         timer_mode_pkg::comb_comp_pwm:  complementary_pwm = 1'b1;
         timer_mode_pkg::comb_reset_pwm: reset_sync_pwm    = 1'b1;
         default:                        complementary_pwm = 1'b0;
      endcase
   end

   assign combined       = complementary_pwm | reset_sync_pwm;
   assign ch2_phase_mode = phase_count_select;                             // R1
   assign buffer_mode    = timer_function_control[timer_mode_pkg::buffer_lsb +: 4];   // R11

   // ********************************
   // PWM pins
   // ********************************
   always_comb
   begin
      pwm_enable    = timer_mode_select[timer_mode_pkg::pwm_lsb +: channels];
      pwm_enable[3] = pwm_enable[3] & ~combined;                           // R7
      pwm_enable[4] = pwm_enable[4] & ~combined;                           // R7
   end

   assign pwm_active = pwm_enable;

   for (genvar ch = 0; ch < channels; ch++)
   begin : g_pwm
      pwm_pin u_pwm
      (
         .pclk      (pclk),
         .presetn   (presetn),
         .enable    (pwm_enable[ch]),
         .match_a   (match_a[ch]),
         .match_b   (match_b[ch]),
         .pin_level (compare_pin_a[ch])
      );
   end

   // ********************************
   // Quadrature input
   // ********************************
   quadrature_decoder u_quad
   (
      .pclk       (pclk),
      .presetn    (presetn),
      .pin_a      (ext_clock_pin_a),
      .pin_b      (ext_clock_pin_b),
      .count_up   (quad_up),
      .count_down (quad_down)
   );

   // ********************************
   // Channel 2 counter
   // ********************************
   assign step_up   = ch2_run & (phase_count_select ? quad_up : ch2_count_tick);   // R3
   assign step_down = ch2_run & phase_count_select & quad_down;                    // R1
   assign wrap_up   = step_up & (counter_reg == timer_mode_pkg::counter_max);      // R15
   assign wrap_down = step_down & (counter_reg == timer_mode_pkg::counter_zero);   // R15

   always_comb
   begin
      counter_next = counter_reg;
      if (ch2_clear)
         counter_next = timer_mode_pkg::counter_zero;                      // R4
      else if (step_up)
         counter_next = counter_reg + counter_width'(1);
      else if (step_down)
         counter_next = counter_reg - counter_width'(1);                   // R2
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         counter_reg <= timer_mode_pkg::counter_zero;
      else if (standby)
         counter_reg <= timer_mode_pkg::counter_zero;
      else if (wr_setup && hit(paddr, timer_mode_pkg::counter_offset))
         counter_reg <= pwdata[counter_width-1:0];
      else
         counter_reg <= counter_next;
   end

   assign channel2_counter = counter_reg;

   // ********************************
   // Overflow flag
   // ********************************
   assign overflow_set = ~ch2_clear & (wrap_up | (wrap_down & ~flag_direction_select));  // R5

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         overflow_reg <= 1'b0;
      else if (standby)
         overflow_reg <= 1'b0;
      else if (overflow_set)
         overflow_reg <= 1'b1;                                             // R5
      else if (wr_setup && hit(paddr, timer_mode_pkg::status_offset)
               && !pwdata[timer_mode_pkg::overflow_flag_bit])
         overflow_reg <= 1'b0;
   end

   assign overflow_flag = overflow_reg;

   // ********************************
   // Read path
   // ********************************
   always_comb
   begin
      read_mux = 32'h0000_0000;
      if (hit(paddr, timer_mode_pkg::mode_offset))
         read_mux[7:0] = timer_mode_select;                                // R12
      else if (hit(paddr, timer_mode_pkg::function_offset))
         read_mux[7:0] = timer_function_control;                           // R12
      else if (hit(paddr, timer_mode_pkg::status_offset))
         read_mux[timer_mode_pkg::overflow_flag_bit] = overflow_reg;
      else if (hit(paddr, timer_mode_pkg::counter_offset))
         read_mux[counter_width-1:0] = counter_reg;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (setup)
      begin
         prdata  <= pwrite ? 32'h0000_0000 : read_mux;
         pslverr <= ~mapped;
      end
   end

endmodule // timer_mode_function_control

// [dv/quadrature_source.sv]
`timescale 1ns/1ps
module quadrature_source
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic step_up,
   input  wire logic step_down,
   output logic      pin_a,
   output logic      pin_b
);
   // ****
   // Gray phase, one pin moves per step
   // ****
   logic [1:0] phase_reg;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         phase_reg <= 2'h3;
      else if (step_up)
         phase_reg <= phase_reg + 2'h1;
      else if (step_down)
         phase_reg <= phase_reg - 2'h1;
   assign pin_a = phase_reg[0] ^ phase_reg[1];
   assign pin_b = ~phase_reg[1];
endmodule // quadrature_source

// [dv/timer_mode_function_control_properties.sv]
`timescale 1ns/1ps
module timer_mode_checks
#(
   parameter int channels      = 5,
   parameter int counter_width = 16
)
(
   input wire logic                     pclk,
   input wire logic                     presetn,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [7:0]               paddr,
   input wire logic [31:0]              pwdata,
   input wire logic [31:0]              prdata,
   input wire logic                     standby,
   input wire logic                     ext_clock_pin_a,
   input wire logic                     ext_clock_pin_b,
   input wire logic                     ch2_run,
   input wire logic                     ch2_count_tick,
   input wire logic                     ch2_clear,
   input wire logic [channels-1:0]      match_a,
   input wire logic [channels-1:0]      match_b,
   input wire logic [channels-1:0]      pwm_active,
   input wire logic [channels-1:0]      compare_pin_a,
   input wire logic [counter_width-1:0] channel2_counter,
   input wire logic                     overflow_flag,
   input wire logic                     ch2_phase_mode,
   input wire logic                     complementary_pwm,
   input wire logic                     reset_sync_pwm,
   input wire logic [3:0]               buffer_mode
);
   // ****
   // Helper state
   // ****
   logic       wr;
   logic [1:0] pins_q;
   logic [2:0] quiet;
   logic       flag_dir_q;
   assign wr = psel && penable && pwrite;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         pins_q <= 2'h0;
      else
         pins_q <= {ext_clock_pin_a, ext_clock_pin_b};
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         quiet <= 3'h0;
      else if (pins_q != {ext_clock_pin_a, ext_clock_pin_b})
         quiet <= 3'h0;
      else if (quiet != 3'h7)
         quiet <= quiet + 3'h1;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         flag_dir_q <= 1'b0;
      else if (standby)
         flag_dir_q <= 1'b0;
      else if (wr && paddr == 8'h00)
         flag_dir_q <= pwdata[5];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_dec;
      ch2_phase_mode && ch2_run && quiet >= 3'h4 &&
      ($rose(ext_clock_pin_a) && !ext_clock_pin_b || $rose(ext_clock_pin_b) && ext_clock_pin_a ||
       $fell(ext_clock_pin_a) && ext_clock_pin_b || $fell(ext_clock_pin_b) && !ext_clock_pin_a);
   endsequence
   sequence s_inc;
      ch2_phase_mode && ch2_run && quiet >= 3'h4 &&
      ($rose(ext_clock_pin_a) && ext_clock_pin_b || $rose(ext_clock_pin_b) && !ext_clock_pin_a ||
       $fell(ext_clock_pin_a) && !ext_clock_pin_b || $fell(ext_clock_pin_b) && ext_clock_pin_a);
   endsequence
   sequence s_wrap;
      !$past(ch2_clear) && !$past(wr) && !$past(standby) &&
      ($past(channel2_counter) == '1 && channel2_counter == '0 ||
       !flag_dir_q && $past(channel2_counter) == '0 && channel2_counter == '1);
   endsequence
   // ****
   // Assertions
   // ****
   a_phase_mode_write: assert property (wr && paddr == 8'h00 && !standby |=> ch2_phase_mode == $past(pwdata[6]))
      else $error("phase mode not taken from write");
   a_comb_field_decode: assert property (wr && paddr == 8'h04 && !standby |=>
      complementary_pwm == ($past(pwdata[5:4]) == 2'h2) && reset_sync_pwm == ($past(pwdata[5:4]) == 2'h3) &&
      buffer_mode == $past(pwdata[3:0])) else $error("function field decode wrong");
   a_pwm_masked: assert property ((complementary_pwm || reset_sync_pwm) |-> pwm_active[4:3] == 2'h0)
      else $error("pwm bits of channels 3 and 4 not masked");
   a_pwm_pin_set: assert property (!wr && !standby |=>
      (compare_pin_a & $past(pwm_active & match_a)) == $past(pwm_active & match_a)) else $error("pin not set");
   a_pwm_pin_clear: assert property (!wr && !standby |=>
      (compare_pin_a & $past(pwm_active & match_b & ~match_a)) == '0) else $error("pin not cleared");
   a_standby_clear: assert property (standby |=> !ch2_phase_mode && pwm_active == '0 && !complementary_pwm &&
      !reset_sync_pwm && buffer_mode == 4'h0 && channel2_counter == '0) else $error("standby did not clear");
   a_fixed_bit_read: assert property (psel && !penable && !pwrite && paddr == 8'h04 |=> prdata[7:6] == 2'h1)
      else $error("function bit 6 or 7 reads wrong");
   a_tick_ignored: assert property (ch2_phase_mode && ch2_count_tick && quiet == 3'h7 && !wr && !ch2_clear &&
      !standby |=> $stable(channel2_counter)) else $error("tick counted in phase mode");
   a_quad_down: assert property (s_dec |-> ##[2:4] channel2_counter == $past(channel2_counter) - 1'b1)
      else $error("quadrature decrement missing");
   a_quad_up: assert property (s_inc |-> ##[2:4] channel2_counter == $past(channel2_counter) + 1'b1)
      else $error("quadrature increment missing");
   a_wrap_flag: assert property (s_wrap |-> ##[0:1] overflow_flag)
      else $error("wrap did not set flag");
endmodule // timer_mode_checks

bind timer_mode_function_control timer_mode_checks #(.channels(channels), .counter_width(counter_width)) checks_u
(
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .standby, .ext_clock_pin_a,
   .ext_clock_pin_b, .ch2_run, .ch2_count_tick, .ch2_clear, .match_a, .match_b, .pwm_active, .compare_pin_a,
   .channel2_counter, .overflow_flag, .ch2_phase_mode, .complementary_pwm, .reset_sync_pwm, .buffer_mode
);

// [dv/timer_mode_function_control_tb.sv]
`timescale 1ns/1ps
module timer_mode_function_control_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        standby, ch2_run, ch2_count_tick, ch2_clear, step_up, step_down, pin_a, pin_b;
   logic [4:0]  match_a, match_b, pwm_active, compare_pin_a;
   logic [15:0] channel2_counter;
   logic        overflow_flag, ch2_phase_mode, complementary_pwm, reset_sync_pwm;
   logic [3:0]  buffer_mode;
   int          n_errors, checks_done;

   timer_mode_function_control dut_u
   (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .standby,
      .ext_clock_pin_a(pin_a), .ext_clock_pin_b(pin_b), .ch2_run, .ch2_count_tick, .ch2_clear, .match_a,
      .match_b, .pwm_active, .compare_pin_a, .channel2_counter, .overflow_flag, .ch2_phase_mode,
      .complementary_pwm, .reset_sync_pwm, .buffer_mode
   );
   quadrature_source quad_u (.pclk, .presetn, .step_up, .step_down, .pin_a, .pin_b);

   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // ****
   // Shared tasks
   // ****
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
         n_errors++;
      end
   endtask

   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20)
      begin
         n_errors++;
         stop_test;
      end
      #1;
   endtask

   task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      chk(nm, rd, exp);
   endtask

   task step(input logic up, input int n);
      repeat (n)
      begin
         @(posedge pclk);
         step_up <= up;
         step_down <= !up;
         ch2_count_tick <= 1'b1;
         @(posedge pclk);
         step_up <= 1'b0;
         step_down <= 1'b0;
         ch2_count_tick <= 1'b0;
         repeat (8) @(posedge pclk);
      end
      #1;
   endtask

   // ****
   // Scenarios
   // ****
   task t_reset;
      rd_chk("mode", 8'h00, 32'h0);
      rd_chk("function", 8'h04, 32'h40);
      chk("mapped_err", 32'(err), 32'h0);
      rd_chk("unmapped", 8'h10, 32'h0);
      chk("unmapped_err", 32'(err), 32'h1);
      $display("test reset done");
   endtask

   task t_fields;
      apb(8'h00, 1'b1, 32'hFF);
      rd_chk("mode_top", 8'h00, 32'h7F);
      apb(8'h04, 1'b1, 32'hCF);
      rd_chk("function_top", 8'h04, 32'h4F);
      chk("buffer", 32'(buffer_mode), 32'hF);
      for (int cm = 0; cm < 4; cm++)
      begin
         apb(8'h04, 1'b1, 32'h40 | (32'(cm) << 4));
         chk("comp", 32'(complementary_pwm), 32'(cm == 2));
         chk("rsync", 32'(reset_sync_pwm), 32'(cm == 3));
         chk("pwm_act", 32'(pwm_active), (cm < 2) ? 32'h1F : 32'h07);
      end
      $display("test fields done");
   endtask

   task t_pwm;
      apb(8'h04, 1'b1, 32'h40);
      apb(8'h00, 1'b1, 32'h1F);
      @(posedge pclk);
      match_a <= 5'h1F;
      @(posedge pclk);
      match_a <= 5'h00;
      match_b <= 5'h1F;
      #1 chk("pin_set", 32'(compare_pin_a), 32'h1F);
      @(posedge pclk);
      match_a <= 5'h1F;
      #1 chk("pin_clr", 32'(compare_pin_a), 32'h00);
      @(posedge pclk);
      match_a <= 5'h00;
      match_b <= 5'h00;
      apb(8'h04, 1'b1, 32'h60);
      @(posedge pclk);
      #1 chk("pin_mask", 32'(compare_pin_a), 32'h07);
      apb(8'h04, 1'b1, 32'h40);
      $display("test pwm done");
   endtask

   task t_quad;
      apb(8'h00, 1'b1, 32'h0);
      apb(8'h0C, 1'b1, 32'h0);
      @(posedge pclk);
      ch2_run <= 1'b1;
      step(1'b1, 2);
      chk("normal", 32'(channel2_counter), 32'h2);
      apb(8'h00, 1'b1, 32'h40);
      apb(8'h0C, 1'b1, 32'h0);
      step(1'b1, 3);
      chk("up", 32'(channel2_counter), 32'h3);
      chk("phase_mode", 32'(ch2_phase_mode), 32'h1);
      step(1'b0, 5);
      chk("down", 32'(channel2_counter), 32'hFFFE);
      rd_chk("flag_under", 8'h08, 32'h1);
      chk("flag_out", 32'(overflow_flag), 32'h1);
      apb(8'h08, 1'b1, 32'h0);
      apb(8'h00, 1'b1, 32'h60);
      apb(8'h0C, 1'b1, 32'h0);
      step(1'b0, 1);
      rd_chk("flag_flag_direction_select", 8'h08, 32'h0);
      step(1'b1, 1);
      rd_chk("flag_over", 8'h08, 32'h1);
      step(1'b1, 1);
      @(posedge pclk);
      ch2_clear <= 1'b1;
      @(posedge pclk);
      ch2_clear <= 1'b0;
      ch2_run <= 1'b0;
      #1 chk("clear", 32'(channel2_counter), 32'h0);
      $display("test quadrature done");
   endtask

   task t_standby;
      apb(8'h00, 1'b1, 32'h7F);
      apb(8'h04, 1'b1, 32'h7F);
      apb(8'h0C, 1'b1, 32'h1234);
      @(posedge pclk);
      standby <= 1'b1;
      @(posedge pclk);
      standby <= 1'b0;
      rd_chk("sb_mode", 8'h00, 32'h0);
      rd_chk("sb_function", 8'h04, 32'h40);
      rd_chk("sb_counter", 8'h0C, 32'h0);
      $display("test standby done");
   endtask

   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite, standby, ch2_run, ch2_count_tick, ch2_clear, step_up, step_down} = 9'h000;
      paddr = 8'h00;
      pwdata = 32'h0;
      match_a = 5'h00;
      match_b = 5'h00;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_fields;
      t_pwm;
      t_quad;
      t_standby;
      stop_test;
   end
endmodule // timer_mode_function_control_tb
